// ### hdl/sml_core.sv
// Status and multiplicand load unit with APB register access
`timescale 1ns/10ps
module sml_core
#(
    parameter int RPT_W  = 8,
    parameter int WAIT_W = 4
)
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              reset_n,
    // APB slave
    input  wire logic [7:0]        paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Instruction issue
    input  wire logic              instr_valid,
    input  wire logic [15:0]       instr_word,
    input  wire logic [15:0]       operand_data,
    input  wire logic              operand_shared,
    input  wire logic              operand_ext,
    input  wire logic [WAIT_W-1:0] wait_d,
    input  wire logic [RPT_W-1:0]  rpt_n,
    output logic                   instr_ready,
    output logic                   done,
    output logic                   accum_op,
    // Addressing fields of the accepted instruction
    output logic                   dm_indirect,
    output logic [6:0]             dm_offset,
    output logic [2:0]             ind_nxt_ptr,
    // Architectural state
    output logic [15:0]            status_word_zero,
    output logic [15:0]            status_word_one,
    output logic [15:0]            primary_multiplicand_reg,
    output logic [4:0]             first_companion_reg,
    output logic [3:0]             second_companion_reg,
    output logic                   multiplicand_copy_mode_bit,
    output logic [15:0]            pc
);
    typedef enum logic [0:0] {st_idle, st_exec} sml_state_t;

    sml_state_t       state, next_state;
    sml_pkg::sml_op_t dec_op, op, next_op;
    logic             dec_ind;
    logic [6:0]       dec_ofs;
    logic [2:0]       dec_narp;
    logic [15:0]      opnd, next_opnd;
    logic             accept, finish, busy;
    logic [1:0]       base;
    logic             apb_acc, apb_wr;
    sml_pkg::sml_reg_t wr_idx, rd_idx;
    logic [15:0]      rd_val;
    logic [15:0]      next_swz, next_swo, next_mul, next_pc;
    logic [4:0]       next_comp1;
    logic [3:0]       next_comp2;
    logic             next_copy;
    logic [31:0]      next_prdata;
    logic             next_pready, next_pslverr;
    logic             next_ready, next_done, next_accum;
    logic             next_ind;
    logic [6:0]       next_ofs;
    logic [2:0]       next_narp;

    // Map a byte address to a register slot
    function automatic sml_pkg::sml_reg_t reg_of(input logic [7:0] a);
        unique case (a)
            sml_pkg::OFS_SWZ:   reg_of = sml_pkg::ri_swz;
            sml_pkg::OFS_SWO:   reg_of = sml_pkg::ri_swo;
            sml_pkg::OFS_MUL:   reg_of = sml_pkg::ri_mul;
            sml_pkg::OFS_COMP1: reg_of = sml_pkg::ri_comp1;
            sml_pkg::OFS_COMP2: reg_of = sml_pkg::ri_comp2;
            sml_pkg::OFS_MODE:  reg_of = sml_pkg::ri_mode;
            sml_pkg::OFS_PC:    reg_of = sml_pkg::ri_pc;
            sml_pkg::OFS_STAT:  reg_of = sml_pkg::ri_stat;
            default:            reg_of = sml_pkg::ri_none;
        endcase
    endfunction

    sml_decode u_decode
    (
        .instr_word  (instr_word),
        .op          (dec_op),
        .indirect    (dec_ind),
        .dm_offset   (dec_ofs),
        .ind_nxt_ptr (dec_narp)
    );

    // Load-status iterations take two cycles, multiplicand loads one
    assign base = (dec_op == sml_pkg::op_mul) ? sml_pkg::MUL_BASE
                                              : sml_pkg::STAT_BASE;
    assign accept = instr_valid && instr_ready &&
                    (dec_op inside {sml_pkg::op_lst0, sml_pkg::op_lst1,
                                    sml_pkg::op_mul});

    sml_timer #(.CNT_W(16), .RPT_W(RPT_W), .WAIT_W(WAIT_W)) u_timer
    (
        .clock   (clock),
        .reset_n (reset_n),
        .start   (accept),
        .base    (base),
        .rpt_n   (rpt_n),
        .shared  (operand_shared),
        .ext     (operand_ext),
        .wait_d  (wait_d),
        .busy    (busy),
        .finish  (finish)
    );

    // Sequencer and latched instruction
    always_comb
    begin
        next_state = state;
        next_op    = op;
        next_opnd  = opnd;
        next_ind   = dm_indirect;
        next_ofs   = dm_offset;
        next_narp  = ind_nxt_ptr;
        unique case (state)
            st_idle:
                if (accept)
                begin
                    next_state = st_exec;
                    next_op    = dec_op;
                    next_opnd  = operand_data;
                    next_ind   = dec_ind;
                    next_ofs   = dec_ofs;
                    next_narp  = dec_narp;
                end
            st_exec:
                if (finish)
                    next_state = st_idle;
        endcase
        // Ready only while idle; no second issue mid-execution
        next_ready = (next_state == st_idle);
        next_done  = (state == st_exec) && finish;
        next_accum = instr_valid && instr_ready &&
                     (dec_op == sml_pkg::op_macc);
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state       <= st_idle;
            op          <= sml_pkg::op_none;
            opnd        <= sml_pkg::RST_WORD;
            dm_indirect <= 1'b0;
            dm_offset   <= '0;
            ind_nxt_ptr <= '0;
            instr_ready <= 1'b1;
            done        <= 1'b0;
            accum_op    <= 1'b0;
        end
        else
        begin
            state       <= next_state;
            op          <= next_op;
            opnd        <= next_opnd;
            dm_indirect <= next_ind;
            dm_offset   <= next_ofs;
            ind_nxt_ptr <= next_narp;
            instr_ready <= next_ready;
            done        <= next_done;
            accum_op    <= next_accum;
        end
    end

    // APB: one wait state so read data comes from a flip-flop
    assign apb_acc = psel && penable && !pready;
    assign apb_wr  = psel && penable && pready && pwrite;
    assign wr_idx  = reg_of(paddr);
    assign rd_idx  = reg_of(paddr);

    // Architectural registers; a commit overrides a same-cycle write
    always_comb
    begin
        next_swz   = status_word_zero;
        next_swo   = status_word_one;
        next_mul   = primary_multiplicand_reg;
        next_comp1 = first_companion_reg;
        next_comp2 = second_companion_reg;
        next_copy  = multiplicand_copy_mode_bit;
        next_pc    = pc;
        if (apb_wr)
        begin
            unique case (wr_idx)
                sml_pkg::ri_swz:   next_swz = pwdata[15:0];
                sml_pkg::ri_swo:   next_swo = pwdata[15:0];
                sml_pkg::ri_mul:   next_mul = pwdata[15:0];
                sml_pkg::ri_comp1:
                    next_comp1 = pwdata[sml_pkg::COMP1_W-1:0];
                sml_pkg::ri_comp2:
                    next_comp2 = pwdata[sml_pkg::COMP2_W-1:0];
                sml_pkg::ri_mode:
                    next_copy = pwdata[sml_pkg::MODE_COPY];
                default: ;
            endcase
        end
        if ((state == st_exec) && finish)
        begin
            next_pc = pc + 16'h0001;
            unique case (op)
                sml_pkg::op_lst0:
                begin
                    // Whole word except mask bit 9, pointer from 15:13, buffer untouched
                    next_swz = opnd;
                    next_swz[sml_pkg::IMASK_BIT] =
                        status_word_zero[sml_pkg::IMASK_BIT];
                    next_swo = status_word_one;
                end
                sml_pkg::op_lst1:
                begin
                    next_swo = opnd;
                    // Latched next pointer never reaches the pointer
                    next_swz[sml_pkg::PTR_HI:sml_pkg::PTR_LO] =
                        opnd[sml_pkg::PTR_HI:sml_pkg::PTR_LO];
                end
                sml_pkg::op_mul:
                begin
                    next_mul = opnd;
                    if (!multiplicand_copy_mode_bit)
                    begin
                        next_comp1 = opnd[sml_pkg::COMP1_W-1:0];
                        next_comp2 = opnd[sml_pkg::COMP2_W-1:0];
                    end
                end
                default: ;
            endcase
        end
        // Read mux, unused upper bits read as zero
        unique case (rd_idx)
            sml_pkg::ri_swz:   rd_val = status_word_zero;
            sml_pkg::ri_swo:   rd_val = status_word_one;
            sml_pkg::ri_mul:   rd_val = primary_multiplicand_reg;
            sml_pkg::ri_comp1: rd_val = {11'h000, first_companion_reg};
            sml_pkg::ri_comp2: rd_val = {12'h000, second_companion_reg};
            sml_pkg::ri_mode:  rd_val = {15'h0000, multiplicand_copy_mode_bit};
            sml_pkg::ri_pc:    rd_val = pc;
            sml_pkg::ri_stat:  rd_val = {15'h0000, busy};
            default:           rd_val = 16'h0000;
        endcase
        next_pready  = apb_acc;
        next_pslverr = apb_acc && (rd_idx == sml_pkg::ri_none);
        next_prdata  = apb_acc ? {16'h0000, rd_val} : prdata;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            status_word_zero           <= sml_pkg::RST_WORD;
            status_word_one            <= sml_pkg::RST_WORD;
            primary_multiplicand_reg   <= sml_pkg::RST_WORD;
            first_companion_reg        <= '0;
            second_companion_reg       <= '0;
            multiplicand_copy_mode_bit <= sml_pkg::RST_COPY;
            pc                         <= sml_pkg::RST_WORD;
            prdata                     <= 32'h0000_0000;
            pready                     <= 1'b0;
            pslverr                    <= 1'b0;
        end
        else
        begin
            status_word_zero           <= next_swz;
            status_word_one            <= next_swo;
            primary_multiplicand_reg   <= next_mul;
            first_companion_reg        <= next_comp1;
            second_companion_reg       <= next_comp2;
            multiplicand_copy_mode_bit <= next_copy;
            pc                         <= next_pc;
            prdata                     <= next_prdata;
            pready                     <= next_pready;
            pslverr                    <= next_pslverr;
        end
    end

    // Checks on committed results and timing
    logic commit;
    logic plain;
    assign commit = (state == st_exec) && finish;
    assign plain  = !operand_ext && !operand_shared && (rpt_n <= 1);

    status_load_a: assert property (@(posedge clock) disable iff (!reset_n)
        commit && op == sml_pkg::op_lst1
        |=> status_word_one == $past(opnd))
        else $error("status one not loaded from operand");
    imask_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
        commit && op == sml_pkg::op_lst0 |=> $stable(
        status_word_zero[sml_pkg::IMASK_BIT]))
        else $error("interrupt mask changed by status zero load");
    pointer_load_a: assert property (@(posedge clock) disable iff (!reset_n)
        commit && op inside {sml_pkg::op_lst0, sml_pkg::op_lst1}
        |=> status_word_zero[15:13] == $past(opnd[15:13]))
        else $error("pointer not loaded from operand bits");
    buffer_keep_a: assert property (@(posedge clock) disable iff (!reset_n)
        commit && op == sml_pkg::op_lst0
        |=> $stable(status_word_one))
        else $error("buffer field changed by status zero load");
    narp_ignore_a: assert property (@(posedge clock) disable iff (!reset_n)
        commit && dm_indirect && op != sml_pkg::op_mul
        && ind_nxt_ptr != opnd[15:13]
        |=> status_word_zero[15:13] != $past(ind_nxt_ptr))
        else $error("next pointer leaked into pointer");
    buffer_copy_a: assert property (@(posedge clock) disable iff (!reset_n)
        commit && op == sml_pkg::op_lst1
        |=> status_word_zero[15:13] == status_word_one[15:13])
        else $error("buffer not copied to pointer");
    status_time_a: assert property (@(posedge clock) disable iff (!reset_n)
        accept && dec_op != sml_pkg::op_mul && plain
        |=> !done ##1 !done ##1 done)
        else $error("status load not two cycles");
    offset_field_a: assert property (@(posedge clock) disable iff (!reset_n)
        accept |=> dm_offset == $past(instr_word[6:0])
                   && ind_nxt_ptr == $past(instr_word[2:0]))
        else $error("operand fields not captured");
    mult_load_a: assert property (@(posedge clock) disable iff (!reset_n)
        commit && op == sml_pkg::op_mul |=> primary_multiplicand_reg ==
        $past(opnd) && pc == $past(pc) + 16'h0001)
        else $error("multiplicand or counter wrong");
    comp_copy_a: assert property (@(posedge clock) disable iff (!reset_n)
        commit && op == sml_pkg::op_mul && !multiplicand_copy_mode_bit
        |=> first_companion_reg == $past(opnd[4:0])
            && second_companion_reg == $past(opnd[3:0]))
        else $error("companions not copied");
    mult_map_a: assert property (@(posedge clock) disable iff (!reset_n)
        apb_wr && wr_idx == sml_pkg::ri_mul && !commit
        |=> primary_multiplicand_reg == $past(pwdata[15:0]))
        else $error("multiplicand not written over bus");
    mult_time_a: assert property (@(posedge clock) disable iff (!reset_n)
        accept && dec_op == sml_pkg::op_mul && plain
        |=> !done ##1 (done && instr_ready))
        else $error("multiplicand load not one cycle");
endmodule // sml_core

// ### hdl/sml_decode.sv
// Instruction word decoder for the load unit
`timescale 1ns/10ps
module sml_decode
(
    // Instruction word in
    input  wire logic [15:0]          instr_word,
    // Decoded fields out
    output sml_pkg::sml_op_t          op,
    output logic                      indirect,
    output logic [6:0]                dm_offset,
    output logic [2:0]                ind_nxt_ptr
);
    // Upper byte picks the operation
    always_comb
    begin
        unique case (instr_word[sml_pkg::OPC_HI:sml_pkg::OPC_LO])
            sml_pkg::OPC_LST0: op = sml_pkg::op_lst0;
            sml_pkg::OPC_LST1: op = sml_pkg::op_lst1;
            sml_pkg::OPC_MUL:  op = sml_pkg::op_mul;
            sml_pkg::OPC_MACC: op = sml_pkg::op_macc;
            default:           op = sml_pkg::op_none;
        endcase
    end
    // Operand fields; 7 and 3 bit wide so any value fits
    assign indirect    = instr_word[sml_pkg::IND_BIT];
    assign dm_offset   = instr_word[sml_pkg::OFS_HI:0];
    assign ind_nxt_ptr = instr_word[sml_pkg::NARP_HI:0];
endmodule // sml_decode

// ### hdl/sml_pkg.sv
// Constants and types for the status and multiplicand load unit
package sml_pkg;
    localparam int          DATA_W    = 16;
    localparam int          APB_AW    = 8;
    // Opcode upper bytes
    localparam logic [7:0]  OPC_LST0  = 8'h0e;
    localparam logic [7:0]  OPC_LST1  = 8'h0f;
    localparam logic [7:0]  OPC_MUL   = 8'h73;
    localparam logic [7:0]  OPC_MACC  = 8'h70;
    // Instruction word fields
    localparam int          OPC_HI    = 15;
    localparam int          OPC_LO    = 8;
    localparam int          IND_BIT   = 7;
    localparam int          OFS_HI    = 6;
    localparam int          NARP_HI   = 2;
    // Status word fields; buffer field sits where the pointer does
    localparam int          PTR_HI    = 15;
    localparam int          PTR_LO    = 13;
    localparam int          IMASK_BIT = 9;
    localparam int          COMP1_W   = 5;
    localparam int          COMP2_W   = 4;
    // Base cycles per iteration
    localparam logic [1:0]  STAT_BASE = 2'h2;
    localparam logic [1:0]  MUL_BASE  = 2'h1;
    // Register byte offsets
    localparam logic [7:0]  OFS_SWZ   = 8'h00;
    localparam logic [7:0]  OFS_SWO   = 8'h04;
    localparam logic [7:0]  OFS_MUL   = 8'h08;
    localparam logic [7:0]  OFS_COMP1 = 8'h0c;
    localparam logic [7:0]  OFS_COMP2 = 8'h10;
    localparam logic [7:0]  OFS_MODE  = 8'h14;
    localparam logic [7:0]  OFS_PC    = 8'h18;
    localparam logic [7:0]  OFS_STAT  = 8'h1c;
    localparam int          MODE_COPY = 0;
    // Reset values
    localparam logic [15:0] RST_WORD  = 16'h0000;
    localparam logic        RST_COPY  = 1'b0;
    typedef enum logic [2:0] {
        op_none, op_lst0, op_lst1, op_mul, op_macc
    } sml_op_t;
    typedef enum logic [3:0] {
        ri_swz, ri_swo, ri_mul, ri_comp1, ri_comp2,
        ri_mode, ri_pc, ri_stat, ri_none
    } sml_reg_t;
endpackage

// ### hdl/sml_timer.sv
// Execution cycle counter for the load unit
`timescale 1ns/10ps
module sml_timer
#(
    parameter int CNT_W  = 16,
    parameter int RPT_W  = 8,
    parameter int WAIT_W = 4
)
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              reset_n,
    // Start request
    input  wire logic              start,
    input  wire logic [1:0]        base,
    input  wire logic [RPT_W-1:0]  rpt_n,
    input  wire logic              shared,
    input  wire logic              ext,
    input  wire logic [WAIT_W-1:0] wait_d,
    // Progress
    output logic                   busy,
    output logic                   finish
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic [CNT_W-1:0] total;
    logic [CNT_W-1:0] n;

    // base*n, plus one for a shared block unless off chip, plus n*d off chip
    always_comb
    begin
        n = (rpt_n == '0) ? CNT_W'(1) : CNT_W'(rpt_n);
        total = CNT_W'(n * CNT_W'(base));
        if (ext)
            total = CNT_W'(total + CNT_W'(n * CNT_W'(wait_d)));
        else if (shared)
            total = CNT_W'(total + CNT_W'(1));
        next_count = count;
        if (start)
            next_count = total;
        else if (count != '0)
            next_count = CNT_W'(count - CNT_W'(1));
    end
    assign busy   = (count != '0);
    assign finish = (count == CNT_W'(1));

    // Count register
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            count <= '0;
        else
            count <= next_count;
    end
endmodule // sml_timer

// ### sim/sml_core_test.sv
// Self-checking testbench for the status and multiplicand load unit
`timescale 1ns/10ps
module sml_core_test;
    logic        clock, reset_n, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, er, instr_valid, instr_ready, done;
    logic [15:0] instr_word, operand_data, status_word_zero, status_word_one;
    logic [15:0] primary_multiplicand_reg, pc, sw0, sw1, t0, epc;
    logic        operand_shared, operand_ext, accum_op, dm_indirect;
    logic [3:0]  wait_d, second_companion_reg, c2;
    logic [7:0]  rpt_n;
    logic [6:0]  dm_offset;
    logic [2:0]  ind_nxt_ptr;
    logic [4:0]  first_companion_reg, c1;
    logic        multiplicand_copy_mode_bit, mode;
    int          fails, n_checks, seed, i;
    logic [7:0]  ops [3] = '{8'h0e, 8'h0f, 8'h73};

    sml_core dut (.clock(clock), .reset_n(reset_n), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .operand_data(operand_data), .operand_shared(operand_shared),
        .operand_ext(operand_ext), .wait_d(wait_d), .rpt_n(rpt_n),
        .instr_ready(instr_ready), .done(done), .accum_op(accum_op),
        .dm_indirect(dm_indirect), .dm_offset(dm_offset),
        .ind_nxt_ptr(ind_nxt_ptr), .status_word_zero(status_word_zero),
        .status_word_one(status_word_one),
        .primary_multiplicand_reg(primary_multiplicand_reg),
        .first_companion_reg(first_companion_reg),
        .second_companion_reg(second_companion_reg),
        .multiplicand_copy_mode_bit(multiplicand_copy_mode_bit), .pc(pc));

    // Free-running core clock, 100 ns period
    always #50 clock = ~clock;

    // Closing report, reached from the main sequence or a timeout
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Value comparison; unknowns never match
    task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Expected execution length, counted in cycles to the commit
    function automatic int cycles(int base, int n, logic sh, logic ex, int d);
        int nn;
        nn = (n == 0) ? 1 : n;
        return base * nn + ((sh && !ex) ? 1 : 0) + (ex ? nn * d : 0);
    endfunction

    // APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, logic [7:0] a, logic [31:0] wd);
        int k;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20)
        begin
            fails++;
            tally_and_finish();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Compare architectural state against the bench model
    task automatic check_state();
        chk("status zero", sw0, status_word_zero);
        chk("status one", sw1, status_word_one);
        chk("multiplicand", t0, primary_multiplicand_reg);
        chk("companion one", c1, first_companion_reg);
        chk("companion two", c2, second_companion_reg);
        chk("pc", epc, pc);
    endtask

    // Issue one instruction, time it and update the model
    task automatic run(input logic [15:0] w, opd, input logic sh, ex,
                       input logic [3:0] d, input logic [7:0] n);
        int k;
        int t;
        @(posedge clock);
        instr_valid <= 1'b1;
        instr_word <= w;
        operand_data <= opd;
        operand_shared <= sh;
        operand_ext <= ex;
        wait_d <= d;
        rpt_n <= n;
        @(posedge clock);
        chk("accept", 1, instr_ready);
        instr_valid <= 1'b0;
        t = cycles((w[15:8] == 8'h73) ? 1 : 2, n, sh, ex, d);
        k = 0;
        do
        begin
            @(posedge clock);
            k++;
            if (k == 1 && t > 0)
                chk("busy ready", 0, instr_ready);
        end while (done !== 1'b1 && k < 300);
        if (k >= 300)
        begin
            fails++;
            tally_and_finish();
        end
        chk("cycles", t + 1, k);
        chk("indirect", w[7], dm_indirect);
        if (!w[7])
            chk("offset", w[6:0], dm_offset);
        else
            chk("next pointer", w[2:0], ind_nxt_ptr);
        epc = epc + 16'h0001;
        if (w[15:8] == 8'h0e)
            sw0 = {opd[15:10], sw0[9], opd[8:0]};
        else if (w[15:8] == 8'h0f)
        begin
            sw1 = opd;
            sw0[15:13] = opd[15:13];
        end
        else
        begin
            t0 = opd;
            if (!mode)
            begin
                c1 = opd[4:0];
                c2 = opd[3:0];
            end
        end
        check_state();
    endtask

    initial
    begin
        seed = 67;
        {fails, n_checks} = 0;
        {clock, reset_n, psel, penable, pwrite, paddr, pwdata} = 0;
        {instr_valid, instr_word, operand_data, operand_shared} = 0;
        {operand_ext, wait_d, rpt_n, mode, sw0, sw1, t0, c1, c2, epc} = 0;
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        chk("idle ready", 1, instr_ready);
        check_state();
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped error", 1, er);
        chk("unmapped data", 0, rd);
        apb(1'b1, 8'h18, 32'h1234);
        // Let the write edge settle before looking at the counter
        @(posedge clock);
        chk("pc write", 0, pc);
        // Interrupt mask bit set, buffer field nonzero before status loads
        apb(1'b1, 8'h00, 32'h0200);
        apb(1'b1, 8'h04, 32'ha000);
        sw0 = 16'h0200;
        sw1 = 16'ha000;
        run(16'h0e85, 16'h0000, 1'b0, 1'b0, 4'h0, 8'h00);
        run(16'h0f7f, 16'hfdff, 1'b1, 1'b0, 4'h0, 8'h01);
        run(16'h7300, 16'hffff, 1'b0, 1'b1, 4'h3, 8'h02);
        apb(1'b1, 8'h14, 32'h1);
        mode = 1'b1;
        run(16'h73ff, 16'h1234, 1'b1, 1'b0, 4'h0, 8'h01);
        // Accumulate variant is only flagged, never executed
        @(posedge clock);
        instr_valid <= 1'b1;
        instr_word <= 16'h7012;
        @(posedge clock);
        instr_valid <= 1'b0;
        @(posedge clock);
        chk("accum flag", 1, accum_op);
        chk("accum ready", 1, instr_ready);
        check_state();
        // Random mix of loads, copy mode and memory timing
        for (i = 0; i < 40; i++)
        begin
            mode = 1'($random(seed));
            apb(1'b1, 8'h14, {31'h0, mode});
            @(posedge clock);
            chk("copy mode", mode, multiplicand_copy_mode_bit);
            run({ops[($random(seed) & 32'h7fff) % 3], 8'($random(seed))},
                16'($random(seed)), 1'($random(seed)), 1'($random(seed)),
                4'($random(seed) & 3), 8'($random(seed) & 3));
        end
        // Memory-mapped readback of the five loadable registers
        apb(1'b1, 8'h08, 32'h5a5a);
        t0 = 16'h5a5a;
        apb(1'b1, 8'h0c, 32'hffff);
        c1 = 5'h1f;
        for (i = 0; i < 5; i++)
        begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk("readback", (i == 0) ? sw0 : (i == 1) ? sw1 : (i == 2) ? t0
                : (i == 3) ? 16'(c1) : 16'(c2), rd);
        end
        tally_and_finish();
    end
endmodule // sml_core_test
